/* File: bench/sruc_host.sv */
// Host-side serial clock model for the update handshake
`timescale 1ns/10ps
module sruc_host (
  input  wire logic run_i,
  output logic      sclk_o
);
  initial sclk_o = 1'b0;
  // Idle low between frames, 160 ns period inside one
  always #80 sclk_o = run_i ? ~sclk_o : 1'b0;
endmodule

/* File: bench/tb_top.sv */
// Testbench for sync and register update control
`timescale 1ns/10ps
module tb_top;
  import sruc_pkg::*;
  logic              core_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic              run = 1'b0, clr = 1'b1, sclk, pd_sync_o, pd_ref_o;
  logic              sync_b = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, d;
  logic [NUM_CH-1:0] ch_hold_o, ch_resync_o, seen;
  int                n_mismatch = 0, tests_run = 0, v, ign = 0;
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) seen <= clr ? '0 : (seen | ch_resync_o);
  sruc_host u_sruc_host (.run_i(run), .sclk_o(sclk));
  sruc_ctrl u_sruc_ctrl (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sclk_i(sclk), .sync_b_i(sync_b), .pd_sync_o, .pd_ref_o, .ch_hold_o, .ch_resync_o);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] w);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= w;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Strobe, then let the host clock run until the pending bit drops
  task automatic upd;
    int i;
    wr(UPDATE_ADDR, 8'h01);
    run <= 1'b1;
    d = 8'hff;
    for (i = 0; i < 40 && d !== 8'h00; i++) rd(UPDATE_ADDR);
    run <= 1'b0;
    if (i == 40) begin
      n_mismatch++;
      wrap_up();
    end else begin
      chk("update self clear", 8'h00, d);
    end
  endtask
  initial begin
    v = $urandom(19635);
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(SYS_CTRL_ADDR);
    chk("sys reset", SYS_RST, d);
    rd(CH_SEL_ADDR);
    chk("select reset", CH_SEL_RST, d);
    rd(10'h3ff);
    chk("unmapped read", RD_ZERO, d);
    $display("test reset done");
    v = $urandom & 32'h6;
    wr(SYS_CTRL_ADDR, v[7:0]);
    rd(SYS_CTRL_ADDR);
    chk("sys buffer", v[7:0], d);
    chk("pd before update", 8'h00, {6'h0, pd_sync_o, pd_ref_o});
    upd();
    chk("pd after update", {6'h0, v[2], v[1]}, {6'h0, pd_sync_o, pd_ref_o});
    $display("test power done");
    wr(SYS_CTRL_ADDR, 8'h01);
    upd();
    chk("hold all", CH_SEL_RST & ~ign[7:0], {3'h0, ch_hold_o});
    ign = 3;
    wr(CH_IGN_ADDR, ign[7:0]);
    upd();
    chk("hold masked", CH_SEL_RST & ~ign[7:0], {3'h0, ch_hold_o});
    wr(SYS_CTRL_ADDR, 8'h00);
    clr <= 1'b0;
    upd();
    repeat (3) @(posedge core_clk_i);
    chk("resync", CH_SEL_RST & ~ign[7:0], {3'h0, seen});
    chk("hold released", 8'h00, {3'h0, ch_hold_o});
    $display("test sync done");
    sync_b <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk("pin hold", CH_SEL_RST & ~ign[7:0], {3'h0, ch_hold_o});
    rd(STATUS_ADDR);
    chk("status", 8'h01, d);
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
    sync_b <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk("pin resync", CH_SEL_RST & ~ign[7:0], {3'h0, seen});
    $display("test pin done");
    wrap_up();
  end
endmodule

/* File: hw/sruc_ctrl.sv */
// Sync and register update control: buffered registers, soft sync and update strobe
`timescale 1ns/10ps
module sruc_ctrl (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic [sruc_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [sruc_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [sruc_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic                           sclk_i,
  input  wire logic                           sync_b_i,
  output logic                                pd_sync_o,
  output logic                                pd_ref_o,
  output logic      [sruc_pkg::NUM_CH-1:0]    ch_hold_o,
  output logic      [sruc_pkg::NUM_CH-1:0]    ch_resync_o
);
  import sruc_pkg::*;

  // Slot numbers inside the buffer and active copies
  localparam int SLOT_SYS = 0;
  localparam int SLOT_IGN = 1;
  localparam int SLOT_SEL = 2;
  localparam int NUM_SLOT = 3;

  // Host-visible buffer copies
  logic [DATA_W-1:0] buf_ff  [NUM_SLOT];
  logic [DATA_W-1:0] nxt_buf [NUM_SLOT];

  // Active copies that steer the outputs
  logic [DATA_W-1:0] act_ff  [NUM_SLOT];
  logic [DATA_W-1:0] nxt_act [NUM_SLOT];

  // Update strobe state
  logic              upd_pend_ff;
  logic              nxt_upd_pend;
  logic              upd_fire;
  logic              upd_wr;

  // Serial clock synchroniser and edge finder
  logic [2:0]        sclk_sync_ff;
  logic [2:0]        nxt_sclk_sync;
  logic              sclk_rise;

  // Sync pin synchroniser
  logic [1:0]        pin_sync_ff;
  logic [1:0]        nxt_pin_sync;
  logic              pin_low;

  // Sync level and release detection
  logic              sync_req;
  logic              sync_lvl_ff;
  logic              nxt_sync_lvl;
  logic [NUM_CH-1:0] sens;
  logic [NUM_CH-1:0] resync_ff;
  logic [NUM_CH-1:0] nxt_resync;

  // Read path
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // Decoded write strobes
  logic              wr_sys;
  logic              wr_ign;
  logic              wr_sel;

  // Writes to unmapped addresses fall through silently
  assign wr_sys = wr_i & (addr_i == SYS_CTRL_ADDR);
  assign wr_ign = wr_i & (addr_i == CH_IGN_ADDR);
  assign wr_sel = wr_i & (addr_i == CH_SEL_ADDR);
  assign upd_wr = wr_i & (addr_i == UPDATE_ADDR) & wdata_i[UPDATE_BIT];

  // Host writes only ever touch the buffers and the update pending flag
  always_comb begin
    for (int i = 0; i < NUM_SLOT; i++) begin
      nxt_buf[i] = buf_ff[i];
    end
    if (wr_sys) begin
      nxt_buf[SLOT_SYS] = {5'h00, wdata_i[PD_SYNC_BIT:0]};
    end
    if (wr_ign) begin
      nxt_buf[SLOT_IGN] = {3'h0, wdata_i[NUM_CH-1:0]};
    end
    if (wr_sel) begin
      nxt_buf[SLOT_SEL] = {3'h0, wdata_i[NUM_CH-1:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_ff[SLOT_SYS] <= SYS_RST;
      buf_ff[SLOT_IGN] <= CH_IGN_RST;
      buf_ff[SLOT_SEL] <= CH_SEL_RST;
    end else begin
      for (int i = 0; i < NUM_SLOT; i++) begin
        buf_ff[i] <= nxt_buf[i];
      end
    end
  end

  // Active copies move only on a transfer
  always_comb begin
    for (int i = 0; i < NUM_SLOT; i++) begin
      nxt_act[i] = act_ff[i];
      if (upd_fire) begin
        nxt_act[i] = buf_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_ff[SLOT_SYS] <= SYS_RST;
      act_ff[SLOT_IGN] <= CH_IGN_RST;
      act_ff[SLOT_SEL] <= CH_SEL_RST;
    end else begin
      for (int i = 0; i < NUM_SLOT; i++) begin
        act_ff[i] <= nxt_act[i];
      end
    end
  end

  // Set wins over the self-clear when a strobe meets a transfer
  always_comb begin
    nxt_upd_pend = upd_pend_ff;
    if (upd_fire) begin
      nxt_upd_pend = 1'b0;
    end
    if (upd_wr) begin
      nxt_upd_pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_pend_ff <= 1'b0;
    end else begin
      upd_pend_ff <= nxt_upd_pend;
    end
  end

  // Two flops tame the serial clock, the third only finds its rise
  always_comb begin
    nxt_sclk_sync = {sclk_sync_ff[1:0], sclk_i};
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_sync_ff <= 3'h0;
    end else begin
      sclk_sync_ff <= nxt_sclk_sync;
    end
  end

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign upd_fire  = upd_pend_ff & sclk_rise;

  // Resets high so no false sync follows reset
  always_comb begin
    nxt_pin_sync = {pin_sync_ff[0], sync_b_i};
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_sync_ff <= 2'h3;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  assign pin_low = ~pin_sync_ff[1];

  // Sync request is low pin or soft sync high; gated by power-down
  assign sync_req = ~act_ff[SLOT_SYS][PD_SYNC_BIT] &
                    (pin_low | act_ff[SLOT_SYS][SOFT_SYNC_BIT]);
  assign sens     = act_ff[SLOT_SEL][NUM_CH-1:0] & ~act_ff[SLOT_IGN][NUM_CH-1:0];

  // Release of the request (pin rise, soft bit fall or sync power-down) starts the resync
  always_comb begin
    nxt_sync_lvl = sync_req;
    nxt_resync   = '0;
    if (sync_lvl_ff && !sync_req) begin
      nxt_resync = sens;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_lvl_ff <= 1'b0;
      resync_ff   <= '0;
    end else begin
      sync_lvl_ff <= nxt_sync_lvl;
      resync_ff   <= nxt_resync;
    end
  end

  // Reads of the three config registers show buffers, so software sees what it wrote before the update
  always_comb begin
    nxt_rdata = RD_ZERO;
    if (rd_i) begin
      case (addr_i)
        SYS_CTRL_ADDR: nxt_rdata = buf_ff[SLOT_SYS];
        CH_IGN_ADDR:   nxt_rdata = buf_ff[SLOT_IGN];
        CH_SEL_ADDR:   nxt_rdata = buf_ff[SLOT_SEL];
        UPDATE_ADDR:   nxt_rdata = {7'h00, upd_pend_ff};
        STATUS_ADDR:   nxt_rdata = {4'h0, act_ff[SLOT_SYS][PD_SYNC_BIT:0], sync_lvl_ff};
        default:       nxt_rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= RD_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o     = rdata_ff;
  assign pd_sync_o   = act_ff[SLOT_SYS][PD_SYNC_BIT];
  assign pd_ref_o    = act_ff[SLOT_SYS][PD_REF_BIT];
  assign ch_hold_o   = sync_lvl_ff ? sens : '0;
  assign ch_resync_o = resync_ff;

  // Checks on the rules this block carries out
  AST_PD_SYNC: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    pd_sync_o |-> ##1 (ch_hold_o == '0))
    else $error("hold active while sync powered down");

  AST_PD_REF: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !upd_fire |=> $stable(pd_ref_o))
    else $error("reference power-down changed without update");

  AST_SOFT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (act_ff[SLOT_SYS][SOFT_SYNC_BIT] && !act_ff[SLOT_SYS][PD_SYNC_BIT]) |=> (ch_hold_o == sens))
    else $error("soft sync did not hold channels");

  AST_RESYNC: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (sync_lvl_ff && !sync_req) |=> (ch_resync_o == $past(sens)))
    else $error("release did not trigger resync");

  AST_UPD_COPY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    upd_fire |=> (act_ff[SLOT_SYS] == $past(buf_ff[SLOT_SYS])))
    else $error("update did not copy buffer");

  AST_UPD_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (upd_fire && !upd_wr) |=> !upd_pend_ff)
    else $error("update strobe did not self-clear");

  AST_IGNORE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ((ch_hold_o | ch_resync_o) & act_ff[SLOT_IGN][NUM_CH-1:0]) == '0)
    else $error("ignoring channel responded to sync");

  AST_BUFFERED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_sys && !upd_fire) |=> (act_ff[SLOT_SYS] == $past(act_ff[SLOT_SYS])))
    else $error("write reached active register directly");

  AST_RD_BUF: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rd_i && addr_i == SYS_CTRL_ADDR) |=> (rdata_o == $past(buf_ff[SLOT_SYS])))
    else $error("read did not return buffer value");

  AST_PEND_SET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    upd_wr |=> upd_pend_ff)
    else $error("update strobe write not taken");

  AST_HOLD_PIN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (pin_low && !act_ff[SLOT_SYS][PD_SYNC_BIT]) |=> (ch_hold_o == sens))
    else $error("low pin did not hold channels");

  AST_REF_COPY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    upd_fire |=> (pd_ref_o == $past(buf_ff[SLOT_SYS][PD_REF_BIT])))
    else $error("reference power-down not taken on update");

  AST_SYNC_PD_COPY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    upd_fire |=> (pd_sync_o == $past(buf_ff[SLOT_SYS][PD_SYNC_BIT])))
    else $error("sync power-down not taken on update");

  AST_MASK_HELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !upd_fire |=>
      (act_ff[SLOT_IGN] == $past(act_ff[SLOT_IGN]) &&
       act_ff[SLOT_SEL] == $past(act_ff[SLOT_SEL])))
    else $error("channel masks changed without update");

  AST_RESYNC_QUIET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !(sync_lvl_ff && !sync_req) |=> (ch_resync_o == '0))
    else $error("resync without a release");

  // Main scenarios
  COV_UPDATE:   cover property (@(posedge core_clk_i) disable iff (!rst_b_i) upd_fire);
  COV_RESYNC:   cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ch_resync_o != '0);
  COV_HOLD:     cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ch_hold_o != '0);
  COV_PIN_HOLD: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) pin_low && sync_lvl_ff);
  COV_REF_PD:   cover property (@(posedge core_clk_i) disable iff (!rst_b_i) pd_ref_o);
endmodule

/* File: hw/sruc_pkg.sv */
// Package with register map, field positions and reset values for sync and update control
package sruc_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 8;
  localparam int          NUM_CH        = 5;
  localparam int          NUM_CFG       = 2;
  localparam logic [9:0]  SYS_CTRL_ADDR = 10'h230;
  localparam logic [9:0]  UPDATE_ADDR   = 10'h232;
  localparam logic [9:0]  CH_IGN_ADDR   = 10'h240;
  localparam logic [9:0]  CH_SEL_ADDR   = 10'h241;
  localparam logic [9:0]  STATUS_ADDR   = 10'h242;
  localparam int          PD_SYNC_BIT   = 2;
  localparam int          PD_REF_BIT    = 1;
  localparam int          SOFT_SYNC_BIT = 0;
  localparam int          UPDATE_BIT    = 0;
  localparam logic [7:0]  SYS_RST       = 8'h00;
  localparam logic [7:0]  CH_IGN_RST    = 8'h00;
  localparam logic [7:0]  CH_SEL_RST    = 8'h1f;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
endpackage
